// ### sepr_sync.sv
// shared constants of the eeprom read path, and a per-bit two-stage synchroniser
// assumes: one system clock with a synchronous active-high reset; inputs are asynchronous pins
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// constants and types
// ------------------------------------------------------------
package sepr_pkg;
  localparam int unsigned ADDR_W = 11;            // array address width, 2048 words
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned HI_W = 3;               // high address bits carried in the slave byte
  localparam logic [3:0] DEV_TYPE = 4'h5;         // arbitrary value, device type identifier
  localparam logic RW_READ = 1'b1;                // read/write bit value that selects a read
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h7;         // index of the eighth bit of a byte
  localparam logic [3:0] BIT_STEP = 4'h1;
  localparam logic [10:0] ADDR_RST = 11'h000;     // address counter after reset
  localparam logic [10:0] ADDR_STEP = 11'h001;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // gray codes along receive-address, acknowledge, transmit, master acknowledge
  typedef enum logic [2:0] {
    SEPR_IDLE      = 3'h0,
    SEPR_DEV_ADDR  = 3'h1,
    SEPR_DEV_ACK   = 3'h3,
    SEPR_TX        = 3'h2,
    SEPR_TX_ACK    = 3'h6,
    SEPR_WAIT_STOP = 3'h7,
    SEPR_WORD_ADDR = 3'h5,
    SEPR_WORD_ACK  = 3'h4
  } sepr_state_e;
endpackage : sepr_pkg

// ------------------------------------------------------------
// two-flop synchroniser, one chain per bit
// ------------------------------------------------------------
module sepr_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output var logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // first stage feeds only the second; pins idle high on an i2c bus
      always_ff @(posedge clk) begin
        if (rst) begin
          meta[i] <= 1'b1;
          q[i] <= 1'b1;
        end else begin
          meta[i] <= d[i];
          q[i] <= meta[i];
        end
      end
    end
  endgenerate
endmodule : sepr_sync

`default_nettype wire

// ### sepr_read_path.sv
// read side of a two-wire serial eeprom slave: address decode, counter, byte output
// assumes: scl and sda are bus pins, the array answers mem_rdata combinationally for
// mem_addr on clk, and a separate write path reports its busy state and counter updates
`timescale 1ns/1ps
`default_nettype none

module sepr_read_path (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [10:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  input wire logic wr_busy,
  input wire logic wr_addr_load,
  input wire logic [10:0] wr_addr
);
  // ------------------------------------------------------------
  // link domain: bit capture and output flop on the bus clock
  // ------------------------------------------------------------
  logic bit_smp;
  logic sda_drv_link;
  logic drv_req;
  logic drive_en;

  // data is stable while scl is high, so the rising edge captures it cleanly
  always_ff @(posedge scl) begin
    bit_smp <= sda_in;
  end

  // drv_req only moves while scl is high, so it is settled at the falling edge
  always_ff @(negedge scl) begin
    sda_drv_link <= drv_req;
  end

  // open drain: only ever pull low; drive_en is cleared from clk on start and stop conditions
  assign sda_out = 1'b0;
  assign sda_oe = sda_drv_link & drive_en;

  // ------------------------------------------------------------
  // pin synchronisers and bus condition detection
  // ------------------------------------------------------------
  logic [1:0] pins_s;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic bus_start;
  logic bus_stop;

  sepr_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d({scl, sda_in}),
    .q(pins_s)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= pins_s[1];
      sda_d <= pins_s[0];
    end
  end

  // start and stop are sda edges while scl stays high
  assign scl_rise = pins_s[1] & ~scl_d;
  assign bus_start = pins_s[1] & scl_d & sda_d & ~pins_s[0];
  assign bus_stop = pins_s[1] & scl_d & ~sda_d & pins_s[0];

  // ------------------------------------------------------------
  // protocol engine, advanced once per scl rising edge
  // ------------------------------------------------------------
  sepr_pkg::sepr_state_e state;
  sepr_pkg::sepr_state_e next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [10:0] addr_cnt;
  logic [10:0] next_addr_cnt;
  logic [2:0] hi_addr;
  logic [2:0] next_hi_addr;
  logic next_drv_req;
  logic next_drive_en;
  logic [7:0] rx_byte;
  logic [10:0] addr_inc;

  assign rx_byte = {shift[6:0], bit_smp};
  assign addr_inc = addr_cnt + sepr_pkg::ADDR_STEP;  // wraps naturally at 11 bits
  assign mem_addr = addr_cnt;

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_addr_cnt = addr_cnt;
    next_hi_addr = hi_addr;
    next_drv_req = drv_req;
    next_drive_en = drive_en;
    // counter updates from the write path, overridden by this block's own loads
    if (wr_addr_load) begin
      next_addr_cnt = wr_addr;
    end
    if (bus_stop) begin
      // release everything and return to standby
      next_state = sepr_pkg::SEPR_IDLE;
      next_drv_req = 1'b0;
      next_drive_en = 1'b0;
    end else if (bus_start) begin
      // a busy write cycle hides the device so that polling sees no acknowledge
      next_state = wr_busy ? sepr_pkg::SEPR_IDLE : sepr_pkg::SEPR_DEV_ADDR;
      next_bit_cnt = sepr_pkg::BIT_FIRST;
      next_drv_req = 1'b0;
      next_drive_en = 1'b0;
    end else if (scl_rise) begin
      // output flop was loaded with drv_req=0 after the start, so enabling here is safe
      next_drive_en = (state != sepr_pkg::SEPR_IDLE);
      unique case (state)
        sepr_pkg::SEPR_IDLE: begin
          next_drv_req = 1'b0;
        end
        sepr_pkg::SEPR_DEV_ADDR: begin
          next_shift = rx_byte;
          next_bit_cnt = bit_cnt + sepr_pkg::BIT_STEP;
          if (bit_cnt == sepr_pkg::BIT_LAST) begin
            if (rx_byte[7:4] == sepr_pkg::DEV_TYPE) begin
              next_hi_addr = rx_byte[3:1];
              next_drv_req = 1'b1;  // acknowledge on the ninth clock
              next_state = sepr_pkg::SEPR_DEV_ACK;
            end else begin
              next_state = sepr_pkg::SEPR_WAIT_STOP;
            end
          end
        end
        sepr_pkg::SEPR_DEV_ACK: begin
          next_bit_cnt = sepr_pkg::BIT_FIRST;
          if (shift[0] == sepr_pkg::RW_READ) begin
            // first byte is the same whether the read is single or sequential
            next_shift = mem_rdata;
            next_drv_req = ~mem_rdata[7];  // msb first
            next_addr_cnt = addr_inc;
            next_state = sepr_pkg::SEPR_TX;
          end else begin
            next_drv_req = 1'b0;
            next_state = sepr_pkg::SEPR_WORD_ADDR;
          end
        end
        sepr_pkg::SEPR_TX: begin
          if (bit_cnt == sepr_pkg::BIT_LAST) begin
            next_drv_req = 1'b0;  // free the line for the master's answer
            next_state = sepr_pkg::SEPR_TX_ACK;
          end else begin
            next_bit_cnt = bit_cnt + sepr_pkg::BIT_STEP;
            next_shift = {shift[6:0], 1'b0};
            next_drv_req = ~shift[6];
          end
        end
        sepr_pkg::SEPR_TX_ACK: begin
          next_bit_cnt = sepr_pkg::BIT_FIRST;
          if (!bit_smp) begin
            // acknowledged: next byte, full counter steps and wraps past the top
            next_shift = mem_rdata;
            next_drv_req = ~mem_rdata[7];
            next_addr_cnt = addr_inc;
            next_state = sepr_pkg::SEPR_TX;
          end else begin
            next_drv_req = 1'b0;  // no acknowledge, wait for stop
            next_state = sepr_pkg::SEPR_WAIT_STOP;
          end
        end
        sepr_pkg::SEPR_WAIT_STOP: begin
          next_drv_req = 1'b0;
        end
        sepr_pkg::SEPR_WORD_ADDR: begin
          next_shift = rx_byte;
          next_bit_cnt = bit_cnt + sepr_pkg::BIT_STEP;
          if (bit_cnt == sepr_pkg::BIT_LAST) begin
            next_addr_cnt = {hi_addr, rx_byte};
            next_drv_req = 1'b1;
            next_state = sepr_pkg::SEPR_WORD_ACK;
          end
        end
        sepr_pkg::SEPR_WORD_ACK: begin
          // data bytes that follow belong to the write path; await a repeated start
          next_drv_req = 1'b0;
          next_state = sepr_pkg::SEPR_WAIT_STOP;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= sepr_pkg::SEPR_IDLE;
      bit_cnt <= sepr_pkg::BIT_FIRST;
      shift <= sepr_pkg::BYTE_RST;
      addr_cnt <= sepr_pkg::ADDR_RST;
      hi_addr <= 3'h0;
      drv_req <= 1'b0;
      drive_en <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      addr_cnt <= next_addr_cnt;
      hi_addr <= next_hi_addr;
      drv_req <= next_drv_req;
      drive_en <= next_drive_en;
    end
  end
endmodule : sepr_read_path

`default_nettype wire

// ### sepr_read_path_asserts.sv
// port checker of the eeprom read path, bound onto every instance
// assumes: wr_addr_load and wr_busy only move while the bus is idle
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// checker
// ----------------------------------------
module sepr_read_path_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [10:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  input wire logic wr_busy,
  input wire logic wr_addr_load,
  input wire logic [10:0] wr_addr
);
  logic [4:0] idle_cnt;
  logic [4:0] next_idle_cnt;
  // idle bus span; saturates so a long idle never looks busy again
  always_comb begin
    next_idle_cnt = (scl && sda_in && idle_cnt != 5'h1F) ? idle_cnt + 5'h01 : idle_cnt;
    if (rst || !(scl && sda_in)) begin
      next_idle_cnt = 5'h00;
    end
  end
  always_ff @(posedge clk) begin
    idle_cnt <= next_idle_cnt;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl)
    else $error("sda drive began while scl high");
  a_out_zero: assert property (sda_out == 1'b0)
    else $error("open-drain data output not zero");
  a_oe_stands: assert property ($rose(sda_oe) |-> sda_oe [*6])
    else $error("driven bit did not stand");
  a_wr_load: assert property (wr_addr_load && scl && sda_in && !sda_oe |=>
    mem_addr == $past(wr_addr))
    else $error("counter not loaded from write side");
  // the engine moves the counter a few clocks after scl rises, so scl is high then;
  // with the device driving, that move is the step after the address acknowledge
  a_addr_step: assert property (scl && sda_oe && $changed(mem_addr) |->
    mem_addr == $past(mem_addr) + 11'h001)
    else $error("counter moved by other than one");
  a_step_once: assert property (scl && $changed(mem_addr) && !$past(wr_addr_load) |=>
    $stable(mem_addr) [*8])
    else $error("counter stepped twice for one byte");
  a_busy_quiet: assert property (wr_busy && $past(wr_busy) && !$past(sda_oe) |-> !sda_oe)
    else $error("answer given during write cycle");
  a_idle_hold: assert property (idle_cnt == 5'h1F && !wr_addr_load |=> $stable(mem_addr))
    else $error("counter moved on idle bus");
  c_ack: cover property ($rose(sda_oe));
  c_wrap: cover property (mem_addr == 11'h000 && $past(mem_addr) == 11'h7FF);
  c_busy: cover property (wr_busy && !scl);
endmodule : sepr_read_path_asserts

bind sepr_read_path sepr_read_path_asserts u_chk (.clk(clk), .rst(rst), .scl(scl),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .mem_addr(mem_addr),
  .mem_rdata(mem_rdata), .wr_busy(wr_busy), .wr_addr_load(wr_addr_load), .wr_addr(wr_addr));
`default_nettype wire

// ### sepr_master.sv
// two-wire bus master model issuing reads; its clock runs only inside frames
// assumes: the bench resolves the open-drain wire with a pull-up and returns it on sda
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// bus master
// ----------------------------------------
module sepr_master (
  output var logic scl,
  output var logic sda_low,
  input wire logic sda
);
  logic [7:0] got_val;
  event done;
  // idle bus: clock stands high, data left to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // data moves mid-low, sampled mid-high; wide margins keep edges apart
  task automatic bit_io(input logic b, output logic s);
    #60 sda_low = ~b;
    #60 scl = 1'b1;
    #40 s = sda;
    #40 scl = 1'b0;
  endtask : bit_io
  task automatic start();
    #1.3; // odd offset keeps bus edges drifting against the system clock
    if (!scl) begin
      #60 sda_low = 1'b0;
      #60 scl = 1'b1;
    end
    #80 sda_low = 1'b1;
    #80 scl = 1'b0;
  endtask : start
  task automatic stop();
    #60 sda_low = 1'b1;
    #60 scl = 1'b1;
    #80 sda_low = 1'b0;
    #200;
  endtask : stop
  // msb first; result is one when the slave acknowledged
  task automatic wbyte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    got_val = {7'h00, ~s};
    ->done;
  endtask : wbyte
  // ack low asks for more, a released ninth bit ends the read
  task automatic rbyte(input logic ack);
    logic s;
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      bit_io(1'b1, s);
      v = {v[6:0], s};
    end
    bit_io(~ack, s);
    got_val = v;
    ->done;
  endtask : rbyte
endmodule : sepr_master
`default_nettype wire

// ### tb.sv
// self-checking bench: master model reads, array and write-side inputs come from here
// assumes: the checker binds itself onto the design
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, rst, scl, sda, sda_low, sda_out, sda_oe, wr_busy, wr_addr_load;
  logic [10:0] mem_addr, wr_addr, ptr;
  logic [7:0] mem [2048];
  logic [7:0] expv;
  logic [7:0] exp_q [$];
  logic [31:0] seed;
  int num_errors = 0;
  int checked = 0;
  assign sda = ~(sda_oe | sda_low); // pull-up unless pulled low
  sepr_master u_m (.scl(scl), .sda_low(sda_low), .sda(sda));
  sepr_read_path u_dut (.clk(clk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .mem_addr(mem_addr), .mem_rdata(mem[mem_addr]), .wr_busy(wr_busy),
    .wr_addr_load(wr_addr_load), .wr_addr(wr_addr));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic addr(input logic [2:0] hi, input logic rw, input logic [7:0] ex);
    exp_q.push_back(ex);
    u_m.start();
    u_m.wbyte({sepr_pkg::DEV_TYPE, hi, rw});
  endtask : addr
  // n bytes from the tracked counter, all but the last acknowledged
  task automatic rd(input int n);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(mem[ptr]);
      ptr = ptr + 11'h001;
      u_m.rbyte(i < n - 1);
    end
    u_m.stop();
  endtask : rd
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // oldest note against each finished byte
  initial begin
    forever begin
      @(u_m.done);
      checked++;
      expv = exp_q.size() ? exp_q.pop_front() : 8'hXX;
      if (u_m.got_val !== expv) begin
        num_errors++;
        $display("ERROR bus byte expected %h seen %h", expv, u_m.got_val);
      end
    end
  end
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    $display("ERROR run expected end seen timeout");
    final_report();
  end
  initial begin
    {rst, wr_busy, wr_addr_load, wr_addr, seed} = {1'b1, 1'b0, 1'b0, 11'h000, 32'h00006465};
    for (int i = 0; i < 2048; i++) begin
      seed = xs(seed);
      mem[i] = seed[7:0];
    end
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    wr_addr <= 11'h7FE;
    wr_addr_load <= 1'b1;
    @(posedge clk);
    wr_addr_load <= 1'b0;
    ptr = 11'h7FE;
    addr(3'h0, 1'b1, 8'h01);
    rd(3);
    $display("test wrap read done");
    addr(3'h5, 1'b1, 8'h01);
    rd(1);
    $display("test byte read done");
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      ptr = seed[10:0];
      addr(ptr[10:8], 1'b0, 8'h01);
      exp_q.push_back(8'h01);
      u_m.wbyte(ptr[7:0]);
      addr(3'h0, 1'b1, 8'h01);
      rd(2);
    end
    $display("test random read done");
    exp_q.push_back(8'h00);
    u_m.start();
    u_m.wbyte({sepr_pkg::DEV_TYPE ^ 4'hF, 3'h0, 1'b1});
    u_m.stop();
    @(posedge clk);
    wr_busy <= 1'b1;
    addr(3'h0, 1'b1, 8'h00);
    u_m.stop();
    @(posedge clk);
    wr_busy <= 1'b0;
    $display("test refusals done");
    repeat (20) @(posedge clk);
    if (exp_q.size() != 0) begin
      num_errors++;
      $display("ERROR pending notes expected 0 seen %0d", exp_q.size());
    end
    final_report();
  end
endmodule : tb
`default_nettype wire
